// [hw/ttc_pkg.sv]
// Shared constants and helpers for the three-channel timer core
package ttc_pkg;
  // Register indices on the internal CPU bus
  localparam logic [3:0] ADDR_STAT = 4'h0;
  localparam logic [3:0] ADDR_CNT0 = 4'h1;
  localparam logic [3:0] ADDR_GR0 = 4'h4;
  // Overflow status and enable register layout
  localparam logic [7:0] STAT_RESET = 8'h88;
  localparam int STAT_ONE_HI = 7;
  localparam int STAT_ONE_LO = 3;
  localparam int STAT_EN_LSB = 4;
  localparam int STAT_FLAG_LSB = 0;
  // Counter and general register values
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] GR_RESET = 16'hFFFF;
  // Counter clear select codes
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
  // I/O control: bit 2 picks capture, bits 1:0 pin mode or capture edge
  localparam int IO_CAP_BIT = 2;
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_LOW = 2'h1;
  localparam logic [1:0] OUT_HIGH = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  // Prescaler select: bit 2 picks an external clock input
  localparam int PSC_EXT_BIT = 2;

  // Byte-lane merge of a CPU write into a 16-bit register
  function automatic logic [15:0] merge_be(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be);
    merge_be = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Edge hit for a sampled input, both edges when bit 1 is set
  function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
    edge_hit = sel[1] ? (prev ^ cur) : (sel == EDGE_FALL) ? (prev & ~cur) : (~prev & cur);
  endfunction
endpackage

// [hw/ttc_chan_if.sv]
// Carrier between the timer top and one counter channel
`timescale 1ns/10ps
interface ttc_chan_if;
  import ttc_pkg::*;
  logic init;
  logic tick;
  logic count_dn;
  logic sync_clr;
  logic [1:0] clr_sel;
  logic [2:0] io_a;
  logic [2:0] io_b;
  logic pwm;
  logic cap_a;
  logic cap_b;
  logic wr_cnt;
  logic wr_gra;
  logic wr_grb;
  logic [1:0] be;
  logic [15:0] wdata;
  logic [15:0] cnt;
  logic [15:0] general_register_a;
  logic [15:0] general_register_b;
  logic wrap;
  logic hit_a;
  logic hit_b;
  logic own_clr;
  logic pin_a;
  logic pin_b;
  logic oe_a;
  logic oe_b;
  modport ctl (output init, tick, count_dn, sync_clr, clr_sel, io_a, io_b, pwm, cap_a, cap_b,
               wr_cnt, wr_gra, wr_grb, be, wdata,
               input cnt, general_register_a, general_register_b, wrap, hit_a, hit_b, own_clr, pin_a, pin_b, oe_a, oe_b);
  modport chan (input init, tick, count_dn, sync_clr, clr_sel, io_a, io_b, pwm, cap_a, cap_b,
                wr_cnt, wr_gra, wr_grb, be, wdata,
                output cnt, general_register_a, general_register_b, wrap, hit_a, hit_b, own_clr, pin_a, pin_b, oe_a, oe_b);
endinterface

// [hw/ttc_channel.sv]
// One timer channel: counter, two general registers, compare and capture
`timescale 1ns/10ps
module ttc_channel import ttc_pkg::*; (
  // Clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Link to the timer top
  ttc_chan_if.chan ch
);
  logic [15:0] cnt_reg, cnt_next, gra_reg, gra_next, grb_reg, grb_next;
  logic capa_prev_reg, capb_prev_reg, pina_reg, pinb_reg;

  // Mode decode; PWM overrides the I/O control setting
  wire cap_mode_a = ch.io_a[IO_CAP_BIT] & ~ch.pwm;
  wire cap_mode_b = ch.io_b[IO_CAP_BIT] & ~ch.pwm;
  wire cap_a = cap_mode_a & edge_hit(capa_prev_reg, ch.cap_a, ch.io_a[1:0]);
  wire cap_b = cap_mode_b & edge_hit(capb_prev_reg, ch.cap_b, ch.io_b[1:0]);
  wire cmp_a = ~cap_mode_a & (cnt_reg == gra_reg);
  wire cmp_b = ~cap_mode_b & (cnt_reg == grb_reg);

  // Clear source and wrap detection
  wire own_clr = ((ch.clr_sel == CLR_A) & (cmp_a | cap_a)) | ((ch.clr_sel == CLR_B) & (cmp_b | cap_b));
  wire clear = own_clr | ((ch.clr_sel == CLR_SYNC) & ch.sync_clr);
  wire at_end = ch.count_dn ? (cnt_reg == CNT_RESET) : (cnt_reg == CNT_MAX);
  wire wrap = ch.tick & ~ch.wr_cnt & ~clear & at_end;

  // Next values: CPU write beats clear, capture and count
  assign cnt_next = ch.init ? CNT_RESET :
                    ch.wr_cnt ? merge_be(cnt_reg, ch.wdata, ch.be) :
                    clear ? CNT_RESET :
                    ch.tick ? (ch.count_dn ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001) :
                    cnt_reg;
  assign gra_next = ch.init ? GR_RESET : ch.wr_gra ? merge_be(gra_reg, ch.wdata, ch.be) :
                    cap_a ? cnt_reg : gra_reg;
  assign grb_next = ch.init ? GR_RESET : ch.wr_grb ? merge_be(grb_reg, ch.wdata, ch.be) :
                    cap_b ? cnt_reg : grb_reg;

  // Pin levels: PWM sets on A match and clears on B match, else per mode
  wire pina_next = ch.pwm ? (cmp_a | (pina_reg & ~cmp_b)) : ~cmp_a ? pina_reg :
                   (ch.io_a[1:0] == OUT_LOW) ? 1'b0 : (ch.io_a[1:0] == OUT_HIGH) ? 1'b1 :
                   (ch.io_a[1:0] == OUT_NONE) ? pina_reg : ~pina_reg;
  wire pinb_next = ~cmp_b ? pinb_reg :
                   (ch.io_b[1:0] == OUT_LOW) ? 1'b0 : (ch.io_b[1:0] == OUT_HIGH) ? 1'b1 :
                   (ch.io_b[1:0] == OUT_NONE) ? pinb_reg : ~pinb_reg;

  // Channel state
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= CNT_RESET;
      gra_reg <= GR_RESET;
      grb_reg <= GR_RESET;
      {capa_prev_reg, capb_prev_reg, pina_reg, pinb_reg} <= 4'h0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      gra_reg <= gra_next;
      grb_reg <= grb_next;
      {capa_prev_reg, capb_prev_reg} <= {ch.cap_a, ch.cap_b};
      pina_reg <= ch.init ? 1'b0 : pina_next;
      pinb_reg <= ch.init ? 1'b0 : pinb_next;
    end
  end

  // Results toward the top
  assign ch.cnt = cnt_reg;
  assign ch.general_register_a = gra_reg;
  assign ch.general_register_b = grb_reg;
  assign ch.wrap = wrap;
  assign ch.hit_a = cmp_a | cap_a;
  assign ch.hit_b = cmp_b | cap_b;
  assign ch.own_clr = own_clr;
  assign ch.pin_a = pina_reg;
  assign ch.pin_b = pinb_reg;
  assign ch.oe_a = ~ch.init & (ch.pwm | (~cap_mode_a & (ch.io_a[1:0] != OUT_NONE)));
  assign ch.oe_b = ~ch.init & ~ch.pwm & ~cap_mode_b & (ch.io_b[1:0] != OUT_NONE);

  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  a_cnt_init: assert property (ce && ch.init |=> cnt_reg == CNT_RESET && gra_reg == GR_RESET)
    else $error("counter or register not initialised");
  a_cpu_wins: assert property (ce && !ch.init && ch.wr_cnt && ch.be == 2'h3 |=>
    cnt_reg == $past(ch.wdata)) else $error("cpu counter write lost");
  a_capture_store: assert property (ce && !ch.init && cap_a && !ch.wr_gra |=>
    gra_reg == $past(cnt_reg)) else $error("capture did not store counter");
  a_clear_match: assert property (ce && !ch.init && clear && !ch.wr_cnt |=>
    cnt_reg == CNT_RESET) else $error("counter not cleared");
endmodule // ttc_channel

// [hw/ttc_top.sv]
// Three-channel 16-bit timer core with overflow status and enable register
`timescale 1ns/10ps
module ttc_top import ttc_pkg::*; #(
  parameter int NUM_CH = 3
) (
  // Clock, reset and power state
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic standby,
  // Internal CPU bus
  input wire logic [3:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [1:0] cpu_be,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  // External clock inputs A to D
  input wire logic [3:0] external_clock,
  // Channel configuration
  input wire logic [NUM_CH-1:0][2:0] prescaler_select,
  input wire logic [NUM_CH-1:0][1:0] counter_clear_select,
  input wire logic [NUM_CH-1:0][2:0] io_control_a,
  input wire logic [NUM_CH-1:0][2:0] io_control_b,
  input wire logic [NUM_CH-1:0] pwm_mode,
  input wire logic [NUM_CH-1:0] sync_group,
  input wire logic phase_mode_flag,
  // Compare and capture pins
  input wire logic [NUM_CH-1:0] pin_a_in,
  input wire logic [NUM_CH-1:0] pin_b_in,
  output logic [NUM_CH-1:0] pin_a_out,
  output logic [NUM_CH-1:0] pin_a_oe,
  output logic [NUM_CH-1:0] pin_b_out,
  output logic [NUM_CH-1:0] pin_b_oe,
  // Events and requests
  output logic [NUM_CH-1:0] match_flag_a,
  output logic [NUM_CH-1:0] match_flag_b,
  output logic [NUM_CH-1:0] ch_wrap_irq
);
  // Clock source pick: divided internal clock or external edge
  function automatic logic sel_tick(input logic [2:0] psel, input logic [2:0] div,
                                    input logic [3:0] ext_rise);
    logic [3:0] inner;
    inner = {&div, &div[1:0], div[0], 1'b1};
    sel_tick = psel[PSC_EXT_BIT] ? ext_rise[psel[1:0]] : inner[psel[1:0]];
  endfunction

  // State
  logic [2:0] div_reg;
  logic [3:0] ext_prev_reg;
  logic [NUM_CH-1:0] en_reg, en_next;
  logic [NUM_CH-1:0] flag_reg, flag_next;
  logic [NUM_CH-1:0] armed_reg, armed_next;
  logic [15:0] rdata_reg;
  logic [15:0] rd_mux;

  // Per-channel results gathered from the channel links
  logic [NUM_CH-1:0] wrap;
  logic [NUM_CH-1:0] own_clr;
  logic [NUM_CH-1:0][15:0] cnt_w;
  logic [NUM_CH-1:0][15:0] gra_w;
  logic [NUM_CH-1:0][15:0] grb_w;

  // External clock edges and phase decode for channel 2
  wire [3:0] ext_rise = external_clock & ~ext_prev_reg;
  wire [3:0] ext_fall = ~external_clock & ext_prev_reg;
  wire phase_tick = ext_rise[0] | ext_fall[0];
  wire phase_dn = ext_rise[0] ? external_clock[1] : ~external_clock[1];

  // Synchronous clear reaches every channel of the group
  wire sync_hit = |(own_clr & sync_group);

  // Status register access decode
  wire stat_sel = cpu_addr == ADDR_STAT;
  wire stat_wr = cpu_wr & stat_sel & cpu_be[0];
  wire stat_rd = cpu_rd & stat_sel;
  wire [NUM_CH-1:0] wr_zero = cpu_wdata[STAT_FLAG_LSB +: NUM_CH] ^ {NUM_CH{1'b1}};
  wire [NUM_CH-1:0] flag_clr = {NUM_CH{stat_wr}} & wr_zero & armed_reg;
  wire [7:0] stat_val = {1'b1, en_reg, 1'b1, flag_reg};

  // Prescaler divider and external input history
  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg <= 3'h0;
      ext_prev_reg <= 4'h0;
    end else if (ce) begin
      div_reg <= div_reg + 3'h1;
      ext_prev_reg <= external_clock;
    end
  end

  // One link and one channel per timer channel
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      ttc_chan_if link();
      wire is_phase = (i == 2) && phase_mode_flag;

      // Clock source and direction; only channel 2 may count down
      assign link.tick = is_phase ? phase_tick :
                         sel_tick(prescaler_select[i], div_reg, ext_rise);
      assign link.count_dn = is_phase & phase_dn;

      // Configuration and capture inputs
      assign link.init = standby;
      assign link.sync_clr = sync_hit & sync_group[i];
      assign link.clr_sel = counter_clear_select[i];
      assign link.io_a = io_control_a[i];
      assign link.io_b = io_control_b[i];
      assign link.pwm = pwm_mode[i];
      assign link.cap_a = pin_a_in[i];
      assign link.cap_b = pin_b_in[i];

      // Register write strobes for this channel
      assign link.wr_cnt = cpu_wr & (cpu_addr == ADDR_CNT0 + 4'(i));
      assign link.wr_gra = cpu_wr & (cpu_addr == ADDR_GR0 + 4'(2 * i));
      assign link.wr_grb = cpu_wr & (cpu_addr == ADDR_GR0 + 4'(2 * i + 1));
      assign link.be = cpu_be;
      assign link.wdata = cpu_wdata;

      // Results back to the top
      assign wrap[i] = link.wrap;
      assign own_clr[i] = link.own_clr;
      assign cnt_w[i] = link.cnt;
      assign gra_w[i] = link.general_register_a;
      assign grb_w[i] = link.general_register_b;
      assign match_flag_a[i] = link.hit_a;
      assign match_flag_b[i] = link.hit_b;
      assign pin_a_out[i] = link.pin_a;
      assign pin_a_oe[i] = link.oe_a;
      assign pin_b_out[i] = link.pin_b;
      assign pin_b_oe[i] = link.oe_b;

      ttc_channel u_chan (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .ch(link.chan)
      );
    end
  endgenerate

  // Flag update: a wrap in the clearing cycle keeps the flag set
  assign flag_next = standby ? {NUM_CH{1'b0}} : (flag_reg & ~flag_clr) | wrap;

  // Read-as-one memory: armed by a status read, dropped by the clear
  assign armed_next = standby ? {NUM_CH{1'b0}} :
                      stat_rd ? flag_reg : armed_reg & ~flag_clr;

  // Enables take the written value; fixed bits ignore writes
  assign en_next = standby ? {NUM_CH{1'b0}} :
                   stat_wr ? cpu_wdata[STAT_EN_LSB +: NUM_CH] : en_reg;

  // Overflow status and enable register
  always_ff @(posedge clk) begin
    if (reset) begin
      en_reg <= STAT_RESET[STAT_EN_LSB +: NUM_CH];
      flag_reg <= STAT_RESET[STAT_FLAG_LSB +: NUM_CH];
      armed_reg <= {NUM_CH{1'b0}};
    end else if (ce) begin
      en_reg <= en_next;
      flag_reg <= flag_next;
      armed_reg <= armed_next;
    end
  end

  // Wrap requests: flag and enable both set
  assign ch_wrap_irq = flag_reg & en_reg;

  // Read data selection; unmapped addresses read zero
  always_comb begin
    rd_mux = 16'h0000;
    case (cpu_addr)
      ADDR_STAT: rd_mux = {8'h00, stat_val};
      4'h1: rd_mux = cnt_w[0];
      4'h2: rd_mux = cnt_w[1];
      4'h3: rd_mux = cnt_w[2];
      4'h4: rd_mux = gra_w[0];
      4'h5: rd_mux = grb_w[0];
      4'h6: rd_mux = gra_w[1];
      4'h7: rd_mux = grb_w[1];
      4'h8: rd_mux = gra_w[2];
      4'h9: rd_mux = grb_w[2];
      default: rd_mux = 16'h0000;
    endcase
  end

  // Registered read data, held until the next read
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
    end else if (ce && cpu_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  assign cpu_rdata = rdata_reg;

  // Checks on status, requests and counting direction
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_status_read;
    ce && stat_rd;
  endsequence

  sequence s_clear_attempt_unread;
    ce && stat_wr && !standby && flag_reg[0] && !armed_reg[0] && !cpu_wdata[0];
  endsequence

  a_status_standby: assert property (ce && standby |=>
    {1'b1, en_reg, 1'b1, flag_reg} == STAT_RESET) else $error("status not 88h after standby");
  a_reserved_ones: assert property (s_status_read |=>
    cpu_rdata[STAT_ONE_HI] && cpu_rdata[STAT_ONE_LO]) else $error("fixed status bit read zero");
  a_irq_gate: assert property (ch_wrap_irq[2] |-> en_reg[2] && flag_reg[2])
    else $error("channel 2 request without flag and enable");
  a_clear_unread: assert property (s_clear_attempt_unread |=> flag_reg[0])
    else $error("flag cleared without prior read");
  a_wrap_flag2: assert property (ce && !standby && wrap[2] |=> flag_reg[2])
    else $error("channel 2 wrap did not set flag");
  a_down_phase: assert property (g_ch[2].link.count_dn |-> phase_mode_flag)
    else $error("channel 2 counting down outside phase mode");
  a_wrap_flag0: assert property (ce && !standby && wrap[0] |=> flag_reg[0] ##1
    (flag_reg[0] || $past(stat_wr))) else $error("channel 0 wrap flag lost");
  a_up_only: assert property (!g_ch[0].link.count_dn && !g_ch[1].link.count_dn)
    else $error("channel 0 or 1 counting down");
  a_count_step: assert property (ce && !standby && g_ch[1].link.tick &&
    !g_ch[1].link.wr_cnt && !g_ch[1].u_chan.clear |=> cnt_w[1] == $past(cnt_w[1]) + 16'h0001)
    else $error("channel 1 did not advance by one");
endmodule // ttc_top

// [tb/ttc_host.sv]
// Host CPU model issuing single-cycle reads and writes on the internal bus
`timescale 1ns/10ps
module ttc_host (
  // Clock
  input wire logic clk,
  // Internal CPU bus
  output logic [3:0] addr,
  output logic rd,
  output logic wr,
  output logic [1:0] be,
  output logic [15:0] wdata
);
  // Idle bus at time zero
  initial begin
    addr = 4'hF;
    rd = 1'b0;
    wr = 1'b0;
    be = 2'h0;
    wdata = 16'h0000;
  end

  // One request held for one rising edge, then released with scrambled lines
  task automatic put(input logic [3:0] a, input logic r, input logic w, input logic [1:0] b,
                     input logic [15:0] d);
    @(negedge clk);
    addr = a;
    rd = r;
    wr = w;
    be = b;
    wdata = d;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
endmodule // ttc_host

// [tb/ttc_top_tb.sv]
// Self-checking bench for the three-channel timer core
`timescale 1ns/10ps
module ttc_top_tb;
  import ttc_pkg::*;
  typedef struct {string name; logic [15:0] val;} ttc_note_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic standby = 1'b0;
  logic [3:0] cpu_addr;
  logic cpu_rd, cpu_wr;
  logic [1:0] cpu_be;
  logic [15:0] cpu_wdata, cpu_rdata;
  logic [3:0] external_clock = 4'h0;
  logic [2:0][2:0] prescaler_select = {3'h7, 3'h7, 3'h7};
  logic [2:0][2:0] io_control_b = '0;
  logic [2:0][1:0] counter_clear_select = '0;
  logic phase_mode_flag = 1'b0;
  logic [2:0] pin_b_in = 3'h0;
  logic [2:0] match_flag_a, match_flag_b, ch_wrap_irq;
  logic [15:0] rnd;
  logic got;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  ttc_note_t notes[$];
  ttc_note_t nt;

  // 50 ns clock
  always #25 clk = ~clk;

  ttc_host host (.clk(clk), .addr(cpu_addr), .rd(cpu_rd), .wr(cpu_wr), .be(cpu_be),
                 .wdata(cpu_wdata));

  ttc_top #(.NUM_CH(3)) dut (
    .clk(clk), .reset(reset), .ce(ce), .standby(standby),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_be(cpu_be),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .external_clock(external_clock),
    .prescaler_select(prescaler_select), .counter_clear_select(counter_clear_select),
    .io_control_a('0),
    .io_control_b(io_control_b), .pwm_mode('0), .sync_group('0),
    .phase_mode_flag(phase_mode_flag), .pin_a_in('0), .pin_b_in(pin_b_in),
    .pin_a_out(), .pin_a_oe(), .pin_b_out(), .pin_b_oe(),
    .match_flag_a(match_flag_a), .match_flag_b(match_flag_b), .ch_wrap_irq(ch_wrap_irq));

  // Comparison of one seen value with its expectation
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Read request with its expected data noted first
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
    notes.push_back('{name, exp});
    host.put(a, 1'b1, 1'b0, 2'h0, 16'h0000);
  endtask

  task automatic wr(input logic [3:0] a, input logic [1:0] b, input logic [15:0] d);
    host.put(a, 1'b0, 1'b1, b, d);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Read data watcher pops the oldest note 1 ns after the rising edge that takes each read
  always @(posedge clk) begin
    if (ce === 1'b1 && cpu_rd === 1'b1) begin
      #1;
      if (notes.size() == 0) begin
        check("unexpected read", cpu_rdata, 16'h0000);
      end else begin
        nt = notes.pop_front();
        check(nt.name, cpu_rdata, nt.val);
      end
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    rnd = $urandom(32'h96da);
    repeat (20) @(negedge clk);
    reset = 1'b0;
    // Status register write masking
    rd(ADDR_STAT, {8'h00, STAT_RESET}, "status after reset");
    wr(ADDR_STAT, 2'h1, 16'h00FF);
    rd(ADDR_STAT, 16'h00F8, "status ones and flags");
    wr(ADDR_STAT, 2'h1, 16'h0010);
    rd(ADDR_STAT, 16'h0098, "status enable 0");
    $display("test status_mask done");
    // Word then byte write of a frozen counter
    rnd = 16'($urandom());
    wr(ADDR_CNT0, 2'h3, rnd);
    wr(ADDR_CNT0, 2'h2, 16'hAB00);
    rd(ADDR_CNT0, {8'hAB, rnd[7:0]}, "counter 0 byte merge");
    wr(ADDR_GR0, 2'h3, 16'h0042);
    wr(ADDR_CNT0, 2'h3, 16'h0042);
    cycles(1);
    check("compare flag a0", 16'(match_flag_a[0]), 16'h0001);
    $display("test access_compare done");
    // Channel 0 overflow, interrupt and clear sequence
    prescaler_select[0] = 3'h0;
    wr(ADDR_CNT0, 2'h3, CNT_MAX);
    cycles(4);
    prescaler_select[0] = 3'h7;
    cycles(1);
    check("irq 0 raised", 16'(ch_wrap_irq), 16'h0001);
    rd(ADDR_STAT, 16'h0099, "status flag 0 set");
    wr(ADDR_STAT, 2'h1, 16'h0010);
    cycles(1);
    check("irq 0 cleared", 16'(ch_wrap_irq), 16'h0000);
    rd(ADDR_STAT, 16'h0098, "status flag 0 clear");
    $display("test overflow0 done");
    // Channel 2 underflow in phase counting mode
    phase_mode_flag = 1'b1;
    external_clock[1] = 1'b1;
    wr(ADDR_CNT0 + 4'h2, 2'h3, CNT_RESET);
    external_clock[0] = 1'b1;
    cycles(6);
    phase_mode_flag = 1'b0;
    cycles(1);
    rd(ADDR_CNT0 + 4'h2, CNT_MAX, "counter 2 down");
    rd(ADDR_STAT, 16'h009C, "status flag 2 set");
    check("irq 2 gated", 16'(ch_wrap_irq), 16'h0000);
    $display("test underflow2 done");
    // Capture into channel 1 register B
    io_control_b[1] = 3'h4;
    rnd = 16'($urandom());
    wr(ADDR_CNT0 + 4'h1, 2'h3, rnd);
    pin_b_in[1] = 1'b1;
    got = 1'b0;
    // Capture event stands only until the next rising edge
    repeat (8) begin
      #1;
      if (match_flag_b[1] === 1'b1)
        got = 1'b1;
      @(negedge clk);
    end
    check("capture flag b1", 16'(got), 16'h0001);
    rd(ADDR_GR0 + 4'h3, rnd, "capture value b1");
    $display("test capture done");
    // Channel 0 cleared by its A compare match
    counter_clear_select[0] = CLR_A;
    wr(ADDR_CNT0, 2'h3, 16'h0042);
    rd(ADDR_CNT0, CNT_RESET, "counter 0 cleared on match");
    counter_clear_select[0] = CLR_NONE;
    $display("test clear_match done");
    // Standby reload then readback of indices 0 to 9 and unmapped index F
    cycles(1);
    standby = 1'b1;
    cycles(2);
    standby = 1'b0;
    rd(ADDR_STAT, 16'h0088, "status after standby");
    for (int i = 1; i < 4; i++)
      rd(4'(i), CNT_RESET, "counter reload");
    for (int i = 4; i < 10; i++)
      rd(4'(i), GR_RESET, "general reload");
    rd(4'hF, 16'h0000, "unmapped read");
    cycles(3);
    $display("test standby done");
    test_done();
  end
endmodule // ttc_top_tb
